/* common/acsr_params.svh */
// constants for the converter serial readout link
// assumes a 10 MHz system clock on both ends
`ifndef ACSR_PARAMS_SVH
`define ACSR_PARAMS_SVH
`define ACSR_CLK_NS 100
`define ACSR_CONV_MAX_NS 1600
`define ACSR_CONV_CYC ((`ACSR_CONV_MAX_NS + `ACSR_CLK_NS - 1) / `ACSR_CLK_NS)
`define ACSR_SCK_HALF 4
`define ACSR_RES_W 16
`define ACSR_BIT_CNT_W 5
`define ACSR_LAST_BIT 5'h10
`define ACSR_CNT_W 8
`define ACSR_FIFO_DEPTH 32
`define ACSR_SAMPLE_INIT 16'h1234
`define ACSR_SAMPLE_STEP 16'h0101
`define ACSR_MSB 15
`endif

/* common/acsr_pkg.sv */
// types for the converter serial readout link
// shared by both ends
package acsr_pkg;
  typedef enum logic [2:0] {ACSR_IDLE, ACSR_CONV, ACSR_WAIT, ACSR_READ, ACSR_DONE} acsr_host_st_t;
  typedef enum logic [0:0] {ACSR_MODE_CHAIN, ACSR_MODE_SEL} acsr_mode_t;
endpackage

/* common/acsr_if.sv */
// link wires between converter end and host end
// serial output and its enable stay separate wires; the host samples the output alone
`timescale 1ns/100ps
interface acsr_if;
  logic convert_line;
  logic sck;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  modport conv (input convert_line, input sck, input sdi, output sdo_o, output sdo_oe);
  modport host (output convert_line, output sck, output sdi, input sdo_o, input sdo_oe);
endinterface

/* src/acsr_fifo.sv */
// parameterised valid/ready fifo
// single clock, synchronous to clk_sys
`timescale 1ns/100ps
module acsr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic do_wr;
  logic do_rd;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[rd_r];
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_r] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (do_rd) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

/* src/acsr_host.sv */
// host end: starts conversions, reads results, three-wire or four-wire
// results pass through a fifo to the user side
`timescale 1ns/100ps
`include "acsr_params.svh"
module acsr_host import acsr_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link
  acsr_if.host lnk,
  // user control
  input wire logic start,
  input wire logic four_wire,
  output logic busy,
  // results
  output logic res_valid,
  input wire logic res_ready,
  output logic [`ACSR_RES_W-1:0] res_data
);
  acsr_host_st_t st_r;
  logic [`ACSR_CNT_W-1:0] cnt_r;
  logic [`ACSR_BIT_CNT_W-1:0] bit_r;
  logic cnv_r, sck_r, sdi_r;
  logic d1_r, d2_r;
  logic [`ACSR_RES_W-1:0] sh_r;
  logic push_r;
  logic f_ready;
  // serial output through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      d1_r <= 1'b0;
      d2_r <= 1'b0;
    end else begin
      d1_r <= lnk.sdo_o;
      d2_r <= d1_r;
    end
  end
  assign lnk.convert_line = cnv_r;
  assign lnk.sck = sck_r;
  assign lnk.sdi = sdi_r;
  // busy until the pushed word is counted, so a full fifo refuses the next start
  assign busy = (st_r != ACSR_IDLE) || push_r;
  // sequencer; a read only starts with fifo room
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ACSR_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      cnv_r <= 1'b0;
      sck_r <= 1'b0;
      sdi_r <= 1'b1;
      sh_r <= '0;
      push_r <= 1'b0;
    end else begin
      push_r <= 1'b0;
      case (st_r)
        ACSR_IDLE: begin
          sdi_r <= 1'b1; // RQ10
          if (start && f_ready && !push_r) begin
            cnv_r <= 1'b1;
            cnt_r <= '0;
            st_r <= ACSR_CONV;
          end
        end
        ACSR_CONV: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == `ACSR_CNT_W'(`ACSR_CONV_CYC)) begin // RQ3 RQ15
            if (four_wire) begin
              sdi_r <= 1'b0; // RQ11
            end else begin
              cnv_r <= 1'b0;
            end
            cnt_r <= '0;
            bit_r <= '0;
            st_r <= ACSR_WAIT;
          end
        end
        ACSR_WAIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == `ACSR_CNT_W'(`ACSR_SCK_HALF)) begin
            cnt_r <= '0;
            st_r <= ACSR_READ;
          end
        end
        ACSR_READ: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == `ACSR_CNT_W'(`ACSR_SCK_HALF)) begin
            cnt_r <= '0;
            if (!sck_r) begin
              sck_r <= 1'b1;
              bit_r <= bit_r + 1'b1;
            end else begin
              // capture on the fall: the bit has stood a full high phase
              sck_r <= 1'b0;
              sh_r <= {sh_r[`ACSR_RES_W-2:0], d2_r}; // RQ8
              if (bit_r == `ACSR_LAST_BIT) begin
                st_r <= ACSR_DONE;
              end
            end
          end
        end
        ACSR_DONE: begin
          cnv_r <= 1'b0;
          sdi_r <= 1'b1;
          push_r <= 1'b1;
          st_r <= ACSR_IDLE;
        end
        default: st_r <= ACSR_IDLE;
      endcase
    end
  end
  acsr_fifo #(.WIDTH(`ACSR_RES_W), .DEPTH(`ACSR_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(push_r),
    .in_ready(f_ready),
    .in_data(sh_r),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule

/* src/acsr_conv.sv */
// converter end: mode capture, timed conversion, serial readout
// link pins come from another domain and are synchronised here
// Notes on behaviour
// RQ1: convert rise samples sdi, selecting mode
// RQ2: sdi tied to convert gives chain
// RQ3: host waits max conversion before readback
// RQ4: three-wire start floats the serial output
// RQ5: conversion end powers down automatically
// RQ6: convert fall presents the result msb
// RQ7: each sck fall shifts next bit
// RQ8: data valid over both sck edges
// RQ9: float at 16th fall or convert rise
// RQ10: three-wire host ties sdi high
// RQ11: four-wire host reads via sdi
// RQ12: chain mode shifts sdi through
// RQ13: conversion timed by internal clock
// RQ14: straight binary result, saturating code; the stand-in sample_r wraps on overflow instead
// RQ15: host holds convert high for conversion
`timescale 1ns/100ps
`include "acsr_params.svh"
module acsr_conv import acsr_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link
  acsr_if.conv lnk,
  // status
  output logic converting,
  output logic powered_down,
  output logic chain_mode
);
  // ==================================================
  // input synchronisers
  logic [2:0] s1_r, s2_r;
  logic cnv_d_r, sck_d_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      cnv_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      s1_r <= {lnk.sdi, lnk.sck, lnk.convert_line};
      s2_r <= s1_r;
      cnv_d_r <= s2_r[0];
      sck_d_r <= s2_r[1];
    end
  end
  logic cnv_s, sck_s, sdi_s;
  assign cnv_s = s2_r[0];
  assign sck_s = s2_r[1];
  assign sdi_s = s2_r[2];
  logic cnv_rise, cnv_fall, sck_fall;
  assign cnv_rise = cnv_s && !cnv_d_r;
  assign cnv_fall = !cnv_s && cnv_d_r;
  assign sck_fall = !sck_s && sck_d_r;
  // ==================================================
  // mode and conversion
  acsr_mode_t mode_r;
  logic [`ACSR_CNT_W-1:0] ccnt_r;
  logic [`ACSR_RES_W-1:0] sample_r;
  logic [`ACSR_RES_W-1:0] sh_r;
  logic out_r, oe_r;
  logic [`ACSR_BIT_CNT_W-1:0] bit_r;
  logic done_pulse;
  assign done_pulse = converting && (ccnt_r == `ACSR_CNT_W'(`ACSR_CONV_CYC - 1));
  assign chain_mode = (mode_r == ACSR_MODE_CHAIN);
  // sdi as seen one cycle before the synchronised rise
  logic sdi_prev_r;
  logic sdi_fall;
  logic sdi_rise;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sdi_prev_r <= 1'b0;
    end else begin
      sdi_prev_r <= sdi_s;
    end
  end
  assign sdi_fall = !sdi_s && sdi_prev_r;
  assign sdi_rise = sdi_s && !sdi_prev_r;
  // a tie of sdi to convert still reads low here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= ACSR_MODE_SEL;
    end else if (cnv_rise) begin
      mode_r <= sdi_prev_r ? ACSR_MODE_SEL : ACSR_MODE_CHAIN; // RQ1 RQ2
    end
  end
  // internal clock times the conversion, sck unused
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      converting <= 1'b0;
    end else if (cnv_rise) begin
      converting <= 1'b1;
    end else if (done_pulse) begin
      converting <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      powered_down <= 1'b1;
    end else if (cnv_rise) begin
      powered_down <= 1'b0;
    end else if (done_pulse) begin
      powered_down <= 1'b1; // RQ5
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ccnt_r <= '0;
    end else if (cnv_rise) begin
      ccnt_r <= '0;
    end else if (converting) begin
      ccnt_r <= ccnt_r + 1'b1; // RQ13
    end
  end
  // stand-in for the analogue result, a straight binary code
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sample_r <= `ACSR_SAMPLE_INIT;
    end else if (done_pulse) begin
      sample_r <= sample_r + `ACSR_SAMPLE_STEP; // RQ14
    end
  end
  // ==================================================
  // serial output
  // outside chain mode, a read starts on convert fall, or on sdi fall with convert high
  logic rd_start;
  logic shift_ev;
  logic last_fall;
  logic chain_load;
  assign rd_start = (cnv_fall || (sdi_fall && cnv_s)) && !chain_mode && !converting && !cnv_rise;
  assign shift_ev = sck_fall && oe_r && !done_pulse && !rd_start && !cnv_rise;
  assign last_fall = shift_ev && !chain_mode && (bit_r == `ACSR_LAST_BIT - 1'b1);
  assign chain_load = done_pulse && chain_mode && !cnv_rise;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sh_r <= '0;
    end else if (done_pulse && !cnv_rise) begin
      sh_r <= chain_mode ? {sample_r[`ACSR_RES_W-2:0], 1'b0} : sample_r;
    end else if (rd_start || shift_ev) begin
      sh_r <= {sh_r[`ACSR_RES_W-2:0], chain_mode && sdi_s}; // RQ12
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_r <= 1'b0;
    end else if (chain_load) begin
      out_r <= sample_r[`ACSR_MSB];
    end else if (rd_start || shift_ev) begin
      out_r <= sh_r[`ACSR_MSB]; // RQ6 RQ7 RQ8
    end
  end
  // four-wire: sdi going high with convert high ends the read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oe_r <= 1'b0;
    end else if (cnv_rise) begin
      oe_r <= 1'b0; // RQ4 RQ9
    end else if (chain_load || rd_start) begin
      oe_r <= 1'b1; // RQ6
    end else if (last_fall) begin
      oe_r <= 1'b0; // RQ9
    end else if (sdi_rise && cnv_s && !chain_mode) begin
      oe_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_r <= '0;
    end else if (cnv_rise || rd_start) begin
      bit_r <= '0;
    end else if (shift_ev && !chain_mode) begin
      bit_r <= bit_r + 1'b1; // RQ7
    end
  end
  assign lnk.sdo_o = out_r;
  assign lnk.sdo_oe = oe_r;
endmodule

/* dv/acsr_props.sv */
// checker on the link wires between the two ends
// instantiated in tb_top beside the joining interface
`timescale 1ns/100ps
module acsr_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link
  input wire logic convert_line,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic [4:0] fall_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // sck falls seen while the output drives
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      fall_r <= 5'h00;
    else if (!sdo_oe)
      fall_r <= 5'h00;
    else if ($fell(sck))
      fall_r <= fall_r + 5'h01;
  end
  // ==========================================
  // properties
  sequence hold_s; (convert_line && !sck) [*8]; endsequence
  sequence sck_hi_s; sck [*5] ##1 !sck; endsequence
  float_on_start_a: assert property ($rose(convert_line) |-> ##[1:4] !sdo_oe)
    else $error("output not floated at start");
  conv_hold_a: assert property ($rose(convert_line) |-> hold_s ##1 hold_s)
    else $error("conversion window broken");
  msb_drive_a: assert property ($fell(convert_line) && sdi |-> ##[1:5] sdo_oe)
    else $error("msb not driven");
  sdi_read_a: assert property ($fell(sdi) && convert_line |-> ##[1:5] sdo_oe)
    else $error("msb not driven on sdi fall");
  bit_stable_a: assert property (sdo_oe && sck && $past(sck) |-> $stable(sdo_o))
    else $error("data moved while sck high");
  float_last_a: assert property (fall_r == 5'h10 |-> ##[0:4] !sdo_oe)
    else $error("output not floated after last bit");
  fall_max_a: assert property (fall_r <= 5'h10)
    else $error("too many bits shifted");
  sck_high_a: assert property ($rose(sck) |-> sck_hi_s)
    else $error("sck high phase wrong");
  sck_low_a: assert property ($fell(sck) |-> !sck [*5])
    else $error("sck low phase wrong");
endmodule

/* dv/tb_top.sv */
// bench: host end against converter end, second converter driven here
// assumes the params header constants for sample start and step
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic four_wire = 1'b0;
  logic res_ready = 1'b0;
  logic busy, res_valid, converting, powered_down, chain_mode, conv_b, pd_b, chain_b;
  logic [15:0] res_data, exp_r;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  acsr_if lnk();
  acsr_if lnk_b();
  // ==========================================
  // instances
  acsr_host i_acsr_host (.clk_sys(clk_sys), .reset_n(reset_n), .lnk(lnk), .start(start),
    .four_wire(four_wire), .busy(busy), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  acsr_conv i_acsr_conv (.clk_sys(clk_sys), .reset_n(reset_n), .lnk(lnk), .converting(converting),
    .powered_down(powered_down), .chain_mode(chain_mode));
  acsr_conv i_acsr_conv_b (.clk_sys(clk_sys), .reset_n(reset_n), .lnk(lnk_b), .converting(conv_b),
    .powered_down(pd_b), .chain_mode(chain_b));
  acsr_props i_acsr_props (.clk_sys(clk_sys), .reset_n(reset_n), .convert_line(lnk.convert_line),
    .sck(lnk.sck), .sdi(lnk.sdi), .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe));
  always #50 clk_sys = ~clk_sys;
  // ==========================================
  // helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task go(input logic fw);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    four_wire = fw;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
  endtask
  // ==========================================
  // scenarios
  task conv1(input logic fw);
    int n;
    go(fw);
    repeat (5) @(negedge clk_sys);
    chk(converting, 1'b1);
    chk(powered_down, 1'b0);
    n = 0;
    while (res_valid !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk(res_valid, 1'b1);
    chk(powered_down, 1'b1);
    chk(res_data, exp_r);
    res_ready = 1'b1;
    @(negedge clk_sys);
    res_ready = 1'b0;
    exp_r = exp_r + 16'h0101;
  endtask
  task fill_drain;
    for (int k = 0; k < 33; k++) begin
      go(k[0]);
      if (k == 32)
        chk(busy, 1'b0);
    end
    res_ready = 1'b1;
    for (int k = 0; k < 32; k++) begin
      chk(res_valid, 1'b1);
      chk(res_data, exp_r);
      exp_r = exp_r + 16'h0101;
      @(negedge clk_sys);
    end
    res_ready = 1'b0;
    chk(res_valid, 1'b0);
  endtask
  task mode_sel;
    logic [15:0] smp;
    smp = 16'h1234 + 16'h0202;
    for (int k = 0; k < 3; k++) begin
      lnk_b.sdi = (k == 2);
      repeat (4) @(negedge clk_sys);
      lnk_b.convert_line = 1'b1;
      lnk_b.sdi = 1'b1;
      repeat (25) @(negedge clk_sys);
      chk(chain_b, k != 2);
      chk(pd_b, 1'b1);
      chk(lnk_b.sdo_oe, k != 2);
      lnk_b.convert_line = 1'b0;
      repeat (5) @(negedge clk_sys);
    end
    chk(lnk_b.sdo_oe, 1'b1);
    chk(lnk_b.sdo_o, smp[15]);
    repeat (3) begin
      lnk_b.sck = 1'b1;
      repeat (4) @(negedge clk_sys);
      lnk_b.sck = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    chk(lnk_b.sdo_o, smp[12]);
    lnk_b.convert_line = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk(lnk_b.sdo_oe, 1'b0);
  endtask
  initial begin
    lnk_b.convert_line = 1'b0;
    lnk_b.sck = 1'b0;
    lnk_b.sdi = 1'b1;
    exp_r = 16'h1234;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(powered_down, 1'b1);
    chk(lnk.sdi, 1'b1);
    conv1(1'b0);
    conv1(1'b1);
    fill_drain();
    mode_sel();
    test_done();
  end
endmodule
